//--- eepc_array.sv
// eeprom cell array with byte-lane program strobes
`timescale 1ns/1ps
`default_nettype none
module eepc_array
   import eepc_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        power_i,
   input  wire logic [6:0]                  rd_addr_i,
   output logic      [7:0]                  rd_data_o,
   input  wire logic [3:0]                  row_i,
   input  wire logic [EEPC_ROW_BYTES-1:0]   lane_we_i,
   input  wire logic [8*EEPC_ROW_BYTES-1:0] row_data_i
);
   localparam int ROWS = EEPC_PAGES * EEPC_PAGE_BYTES / EEPC_ROW_BYTES;

   // one bank of cells per byte lane, indexed by row
   logic [7:0] cells [EEPC_ROW_BYTES][ROWS];

   // --------------------------------------------------------------
   // per-lane program; each lane owns its bank, untouched lanes keep contents
   // --------------------------------------------------------------
   for (genvar g = 0; g < EEPC_ROW_BYTES; g++) begin : g_lane
      always_ff @(posedge clk_i) begin
         if (power_i && lane_we_i[g]) begin
            cells[g][row_i] <= row_data_i[8*g +: 8];
         end
      end
   end

   // registered read, zero while powered down
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !power_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= cells[rd_addr_i[2:0]][rd_addr_i[6:3]];
      end
   end
endmodule
`default_nettype wire

//--- eepc_cpu_model.sv
// cpu data-space model that drives the eeprom controller
`timescale 1ns/1ps
`default_nettype none
module eepc_cpu_model
   import eepc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       busy_i,
   input  wire logic       rvalid_i,
   input  wire logic [7:0] rdata_i,
   output var  eepc_req_t  req_o
);
   // ---------------------------------------------------------------
   // access tasks, one strobe cycle each
   // ---------------------------------------------------------------
   logic row_write_mode = 1'b0; // shadow of the write-only parallel mode bit

   initial req_o = '0;

   // write strobe, taken at the second edge
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      if (a == EEPC_BANK_ADDR && row_write_mode) return; // page held in parallel mode
      if (a == EEPC_CTRL_ADDR && busy_i !== 1'b1) row_write_mode = d[EEPC_BIT_ROW_WRITE_MODE];
      @(posedge clk_i);
      req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_i);
      req_o.wr <= 1'b0;
   endtask

   // read strobe, answer sampled once settled
   task automatic read(input logic [7:0] a, output logic [7:0] q, output logic v);
      q = 8'h00;
      v = 1'b0;
      if (a <= EEPC_WIN_LAST && row_write_mode) return; // no array reads in parallel mode
      @(posedge clk_i);
      req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req_o.rd <= 1'b0;
      #1;
      q = rdata_i;
      v = rvalid_i;
   endtask

   // poll busy until clear, counting the cycles it stands
   task automatic wait_idle(output int n);
      n = 0;
      #1;
      while (busy_i === 1'b1 && n < 50) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n > 0) row_write_mode = 1'b0; // parallel mode ends with the cycle
   endtask
endmodule
`default_nettype wire

//--- eepc_ctrl.sv
// eeprom control register, row latches and program sequencer
// Functional notes
// - halt instruction powers the array down at the next clock edge.
// - parallel mode turns array writes into row loads, latching row and data; array reads refused.
// - once row latched, other rows are not reachable.
// - entering parallel mode clears eight row latches and markers.
// - row cycle programs only bytes loaded since parallel mode enable.
// - parallel mode bit clears itself when the row cycle ends.
// - start only takes effect with enable and parallel mode set.
// - control register at eah, reset 00h, bits 7,5,4 read zero.
// - standby bit 6 disables array and access.
// - start bit 3 programs the row; clears at the end.
// - parallel mode bit 2; row is page bit and a5..a3, byte a2..a0.
// - clearing parallel mode before start abandons the row.
// - busy bit 1 set for the whole programming cycle.
// - array access during busy is aborted; cycle still completes.
// - enable bit 0 gates programming; no cycle when low.
// - while busy, control writes ignored, only busy readable.
// - outside parallel mode each write programs one byte.
// - bank register bits 0 and 1 pick page at 00h..3fh.
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl
   import eepc_pkg::*;
#(
   parameter int PROG_CYCLES = EEPC_PROG_CYCLES
)(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       halt_i,
   input  wire logic       rd_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o,
   output logic            rvalid_o,
   output logic            busy_o,
   output logic            array_power_o
);
   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic                        standby;
      logic                        row_write_mode;
      logic                        enable;
      logic                        start;
      logic                        halted;
      logic [1:0]                  bank;
      eepc_mode_t                  mode;
      logic [EEPC_CNT_W-1:0]       cnt;
      logic                        row_valid;
      logic [3:0]                  row;
      logic [EEPC_ROW_BYTES-1:0]   loaded;
      logic [8*EEPC_ROW_BYTES-1:0] data;
      logic [EEPC_ROW_BYTES-1:0]   lane_we;
      logic                        rd_pend;
      logic                        rd_ctrl;
      logic [7:0]                  ctrl_rd;
   } eepc_state_t;

   eepc_state_t st;
   eepc_state_t next_st;
   eepc_req_t   req;
   logic [7:0]  arr_rd;
   logic        in_win;
   logic        page_ok;
   logic [6:0]  arr_addr;
   logic        powered;

   assign req = '{rd: rd_i, wr: wr_i, addr: addr_i, wdata: wdata_i};

   // page decode from bank bits, used for read and write
   function automatic logic page_sel(input logic [1:0] b);
      return b[EEPC_BIT_PAGE1];
   endfunction

   assign in_win   = (req.addr <= EEPC_WIN_LAST);
   assign page_ok  = st.bank[EEPC_BIT_PAGE0] ^ st.bank[EEPC_BIT_PAGE1];
   assign arr_addr = {page_sel(st.bank), req.addr[5:0]};
   assign powered  = !st.standby && !st.halted;

   // --------------------------------------------------------------
   // next-state logic
   // --------------------------------------------------------------
   always_comb begin
      next_st         = st;
      next_st.lane_we = '0;
      next_st.rd_pend = 1'b0;
      next_st.rd_ctrl = 1'b0;
      if (halt_i) begin
         next_st.halted = 1'b1;
      end
      // programming sequencer
      unique case (st.mode)
         EEPC_IDLE: begin
         end
         EEPC_PROG_BYTE, EEPC_PROG_ROW: begin
            if (st.cnt == EEPC_CNT_W'(PROG_CYCLES - 1)) begin
               next_st.mode = EEPC_IDLE;
               next_st.cnt  = '0;
               if (st.mode == EEPC_PROG_ROW) begin
                  next_st.row_write_mode     = 1'b0;
                  next_st.start     = 1'b0;
                  next_st.row_valid = 1'b0;
                  next_st.loaded    = '0;
               end
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
      endcase
      // control register write, ignored while busy
      if (req.wr && req.addr == EEPC_CTRL_ADDR && st.mode == EEPC_IDLE) begin
         next_st.standby = req.wdata[EEPC_BIT_STANDBY];
         next_st.enable  = req.wdata[EEPC_BIT_ENABLE];
         next_st.row_write_mode   = req.wdata[EEPC_BIT_ROW_WRITE_MODE];
         if (req.wdata[EEPC_BIT_ROW_WRITE_MODE] && !st.row_write_mode) begin
            next_st.loaded    = '0;
            next_st.data      = '0;
            next_st.row_valid = 1'b0;
         end
         if (!req.wdata[EEPC_BIT_ROW_WRITE_MODE]) begin
            next_st.row_valid = 1'b0;
            next_st.loaded    = '0;
         end
         if (req.wdata[EEPC_BIT_START] && req.wdata[EEPC_BIT_ENABLE] && st.row_write_mode
             && req.wdata[EEPC_BIT_ROW_WRITE_MODE] && st.enable && st.row_valid && powered) begin
            next_st.start   = 1'b1;
            next_st.mode    = EEPC_PROG_ROW;
            next_st.cnt     = '0;
            next_st.lane_we = st.loaded;
         end
      end
      // bank register write
      if (req.wr && req.addr == EEPC_BANK_ADDR) begin
         next_st.bank = req.wdata[1:0];
      end
      // array window write
      if (req.wr && in_win && page_ok && powered && st.mode == EEPC_IDLE) begin
         if (st.row_write_mode) begin
            if (!st.row_valid || st.row == arr_addr[6:3]) begin
               next_st.row_valid = 1'b1;
               next_st.row       = arr_addr[6:3];
               next_st.loaded[arr_addr[2:0]]       = 1'b1;
               next_st.data[8*arr_addr[2:0] +: 8] = req.wdata;
            end
         end else if (st.enable) begin
            next_st.row                         = arr_addr[6:3];
            next_st.data[8*arr_addr[2:0] +: 8] = req.wdata;
            next_st.lane_we                     = '0;
            next_st.lane_we[arr_addr[2:0]]      = 1'b1;
            next_st.mode                        = EEPC_PROG_BYTE;
            next_st.cnt                         = '0;
         end
      end
      // reads: array when idle, control register any time
      if (req.rd && in_win && page_ok && powered && st.mode == EEPC_IDLE && !st.row_write_mode) begin
         next_st.rd_pend = 1'b1;
      end
      if (req.rd && req.addr == EEPC_CTRL_ADDR) begin
         next_st.rd_ctrl = 1'b1;
         next_st.ctrl_rd = EEPC_CTRL_RESET;
         next_st.ctrl_rd[EEPC_BIT_BUSY] = (st.mode != EEPC_IDLE);
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st      <= '0;
         st.mode <= EEPC_IDLE;
      end else begin
         st <= next_st;
      end
   end

   eepc_array u_array (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .power_i    (powered),
      .rd_addr_i  (arr_addr),
      .rd_data_o  (arr_rd),
      .row_i      (st.row),
      .lane_we_i  (st.lane_we),
      .row_data_i (st.data)
   );

   // outputs
   assign busy_o        = (st.mode != EEPC_IDLE);
   assign array_power_o = powered;
   assign rvalid_o      = st.rd_pend | st.rd_ctrl;
   assign rdata_o       = st.rd_ctrl ? st.ctrl_rd : (st.rd_pend ? arr_rd : 8'h00);

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   halt_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      halt_i |=> !array_power_o) else $error("array powered after halt");
   row_write_mode_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == EEPC_CTRL_ADDR && !busy_o && wdata_i[EEPC_BIT_ROW_WRITE_MODE] && !st.row_write_mode) |=> st.loaded == '0)
      else $error("row markers not cleared");
   row_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($fell(busy_o) && $past(st.mode) == EEPC_PROG_ROW) |-> !st.row_write_mode && !st.start)
      else $error("parallel mode left set");
   start_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == EEPC_CTRL_ADDR && !busy_o && !(st.enable && st.row_write_mode)) |=> !st.start)
      else $error("start without enable");
   busy_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(busy_o) |-> busy_o[*8]) else $error("busy too short");
   busy_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (busy_o && wr_i && addr_i == EEPC_CTRL_ADDR && !next_st.halted) |=> $stable(st.enable))
      else $error("control written while busy");
   no_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!busy_o && !st.enable) |=> !busy_o) else $error("cycle without enable");
   row_lanes_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (st.lane_we != '0) |-> (st.lane_we & ~$past(st.loaded)) == '0 || st.mode == EEPC_PROG_BYTE)
      else $error("unloaded byte programmed");
endmodule
`default_nettype wire

//--- eepc_ctrl_bench.sv
// self-checking bench for the eeprom parallel write controller
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl_bench
   import eepc_pkg::*;
;
   // ---------------------------------------------------------------
   // clock, reset, design and cpu model
   // ---------------------------------------------------------------
   localparam int PC = 10;
   logic       clk_i   = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       halt_i  = 1'b0;
   eepc_req_t  req;
   logic [7:0] rdata;
   logic       rvalid;
   logic       busy;
   logic       power;
   logic [7:0] q;
   logic       v;
   logic [7:0] img [8];
   int         n_fail = 0;
   int         total_checks = 0;
   int         n;

   // 125 MHz clock
   always #4 clk_i = ~clk_i;

   eepc_ctrl #(.PROG_CYCLES(PC)) uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .halt_i(halt_i), .rd_i(req.rd), .wr_i(req.wr),
      .addr_i(req.addr), .wdata_i(req.wdata), .rdata_o(rdata), .rvalid_o(rvalid),
      .busy_o(busy), .array_power_o(power));

   eepc_cpu_model cpu (.clk_i(clk_i), .busy_i(busy), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));

   // ---------------------------------------------------------------
   // compare, access and report tasks
   // ---------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d failures=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // poll busy, compare its length against len, give up on a hang
   task automatic settle(input int len);
      cpu.wait_idle(n);
      if (n >= 50) begin
         n_fail++;
         results();
      end
      chk8(8'(n), 8'(len));
   endtask

   // write, then compare the busy length against len
   task automatic wrp(input logic [7:0] a, input logic [7:0] d, input int len);
      cpu.write(a, d);
      settle(len);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic ev);
      cpu.read(a, q, v);
      chk1(v, ev);
      if (ev) chk8(q, e);
   endtask

   task automatic check_row();
      for (int i = 0; i < 8; i++) rdc(8'h18 + 8'(i), img[i], 1'b1);
   endtask

   // main sequence
   initial begin
      for (int i = 0; i < 8; i++) img[i] = 8'h10 + 8'(i);
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk1(power, 1'b1);
      chk1(busy, 1'b0);
      rdc(EEPC_CTRL_ADDR, EEPC_CTRL_RESET, 1'b1);
      rdc(8'h18, 8'h00, 1'b0);
      wrp(EEPC_BANK_ADDR, 8'h01, 0);
      wrp(EEPC_CTRL_ADDR, 8'h01, 0);
      rdc(EEPC_CTRL_ADDR, 8'h00, 1'b1);
      for (int i = 0; i < 8; i++) wrp(8'h18 + 8'(i), img[i], PC);
      wrp(8'h20, 8'h33, PC);
      wrp(EEPC_BANK_ADDR, 8'h02, 0);
      wrp(8'h18, 8'hee, PC);
      rdc(8'h18, 8'hee, 1'b1);
      wrp(EEPC_BANK_ADDR, 8'h01, 0);
      check_row();
      // two pages at once: array refused
      wrp(EEPC_BANK_ADDR, 8'h03, 0);
      rdc(8'h18, 8'h00, 1'b0);
      wrp(8'h18, 8'h77, 0);
      wrp(EEPC_BANK_ADDR, 8'h01, 0);
      rdc(8'h18, img[0], 1'b1);
      // accesses while a byte cycle runs
      cpu.write(8'h1f, 8'h5a);
      img[7] = 8'h5a;
      rdc(EEPC_CTRL_ADDR, 8'h02, 1'b1);
      rdc(8'h18, 8'h00, 1'b0);
      cpu.write(EEPC_CTRL_ADDR, 8'h40);
      cpu.write(8'h1e, 8'hff);
      settle(PC - 8);
      chk1(power, 1'b1);
      check_row();
      // byte write with programming disabled
      wrp(EEPC_CTRL_ADDR, 8'h00, 0);
      wrp(8'h18, 8'h55, 0);
      rdc(8'h18, img[0], 1'b1);
      // start refused without enable and parallel mode
      wrp(EEPC_CTRL_ADDR, 8'h09, 0);
      wrp(EEPC_CTRL_ADDR, 8'h04, 0);
      wrp(8'h18, 8'h66, 0);
      wrp(EEPC_CTRL_ADDR, 8'h0c, 0);
      wrp(EEPC_CTRL_ADDR, 8'h00, 0);
      check_row();
      // partial row program, foreign row ignored
      wrp(EEPC_CTRL_ADDR, 8'h05, 0);
      wrp(8'h18, 8'ha0, 0);
      wrp(8'h1a, 8'ha2, 0);
      wrp(8'h1b, 8'ha3, 0);
      wrp(8'h20, 8'hbb, 0);
      wrp(EEPC_CTRL_ADDR, 8'h0d, PC);
      img[0] = 8'ha0;
      img[2] = 8'ha2;
      img[3] = 8'ha3;
      check_row();
      rdc(8'h20, 8'h33, 1'b1);
      rdc(EEPC_CTRL_ADDR, 8'h00, 1'b1);
      wrp(EEPC_CTRL_ADDR, 8'h0d, 0);
      // abandoned row, then latches cleared on re-entry
      wrp(EEPC_CTRL_ADDR, 8'h05, 0);
      wrp(8'h19, 8'h99, 0);
      wrp(EEPC_CTRL_ADDR, 8'h01, 0);
      wrp(EEPC_CTRL_ADDR, 8'h05, 0);
      wrp(8'h1e, 8'he6, 0);
      wrp(EEPC_CTRL_ADDR, 8'h0d, PC);
      img[6] = 8'he6;
      check_row();
      // standby and halt power the array down
      wrp(EEPC_CTRL_ADDR, 8'h40, 0);
      chk1(power, 1'b0);
      rdc(8'h18, 8'h00, 1'b0);
      wrp(EEPC_CTRL_ADDR, 8'h01, 0);
      chk1(power, 1'b1);
      @(posedge clk_i);
      halt_i <= 1'b1;
      @(posedge clk_i);
      halt_i <= 1'b0;
      #1;
      chk1(power, 1'b0);
      rdc(8'h18, 8'h00, 1'b0);
      wrp(EEPC_CTRL_ADDR, 8'h01, 0);
      chk1(power, 1'b0);
      results();
   end
endmodule
`default_nettype wire

//--- eepc_pkg.sv
// package for the eeprom parallel write controller
package eepc_pkg;
   // ---------------------------------------------------------------
   // data space map
   // ---------------------------------------------------------------
   localparam logic [7:0] EEPC_CTRL_ADDR   = 8'hea;
   localparam logic [7:0] EEPC_BANK_ADDR   = 8'he8;
   localparam logic [7:0] EEPC_WIN_LAST    = 8'h3f;
   localparam logic [7:0] EEPC_CTRL_RESET  = 8'h00;
   localparam logic [7:0] EEPC_BANK_RESET  = 8'h00;
   // ---------------------------------------------------------------
   // control and bank register fields
   // ---------------------------------------------------------------
   localparam int EEPC_BIT_STANDBY = 6;
   localparam int EEPC_BIT_START   = 3;
   localparam int EEPC_BIT_ROW_WRITE_MODE   = 2;
   localparam int EEPC_BIT_BUSY    = 1;
   localparam int EEPC_BIT_ENABLE  = 0;
   localparam int EEPC_BIT_PAGE0   = 0;
   localparam int EEPC_BIT_PAGE1   = 1;
   // ---------------------------------------------------------------
   // array geometry and timing
   // ---------------------------------------------------------------
   localparam int EEPC_ROW_BYTES   = 8;
   localparam int EEPC_PAGE_BYTES  = 64;
   localparam int EEPC_PAGES       = 2;
   localparam int EEPC_PROG_CYCLES = 1000;
   localparam int EEPC_CNT_W       = 16;

   // ---------------------------------------------------------------
   // cpu data space request
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } eepc_req_t;

   typedef enum logic [1:0] {EEPC_IDLE, EEPC_PROG_BYTE, EEPC_PROG_ROW} eepc_mode_t;
endpackage
